// ---- nand_bpe_pkg.sv ----
// Constants shared by the busy, write-protect and ECC-enable logic.
// Assumes a 25 MHz core clock and an SPI link sampled by that clock.
`default_nettype none

package nand_bpe_pkg;

  // Instruction opcodes seen on the serial link.
  localparam logic [7:0] OP_GET_FEAT = 8'h0F;
  localparam logic [7:0] OP_SET_FEAT = 8'h1F;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_DEV_RESET = 8'hFF;

  // Feature (status) register addresses.
  localparam logic [7:0] FEAT_PROT = 8'hA0;
  localparam logic [7:0] FEAT_CFG = 8'hB0;
  localparam logic [7:0] FEAT_STAT = 8'hC0;

  // Field positions inside the feature bytes.
  localparam int PROT_TB_POS = 2;
  localparam int PROT_BP_LSB = 3;
  localparam int CFG_ECC_POS = 4;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_EFAIL_POS = 2;
  localparam int STAT_PFAIL_POS = 3;

  // Values after reset.
  localparam logic ECC_EN_RST = 1'b1;
  localparam logic TB_RST = 1'b0;
  localparam logic [3:0] BP_RST = 4'h0;

  // Correction strength of the array ECC engine, in bits per sector.
  localparam int ECC_MAX_CORRECT = 8;

  // Identification bytes; the values are arbitrary.
  localparam logic [7:0] ID_MAKER = 8'h5A;
  localparam logic [15:0] ID_DEVICE = 16'h1234;

  // Register bus byte offsets.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;

  // Interrupt bit positions.
  localparam int IRQ_DONE_POS = 0;
  localparam int IRQ_REJECT_POS = 1;
  localparam int IRQ_IGNORED_POS = 2;
  localparam int IRQ_W = 3;

  // Internal operation times and their cycle counts (rounded up).
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_PWRUP_NS = 100000;
  localparam int T_READ_NS = 180000;
  localparam int T_PROG_NS = 450000;
  localparam int T_ERASE_NS = 3500000;
  localparam int PWRUP_CYC = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 17;

  typedef enum logic [1:0] {OPK_NONE, OPK_READ, OPK_PROG, OPK_ERASE} op_kind_e;

endpackage

`default_nettype wire

// ---- nand_protect_range.sv ----
// Decodes top/bottom select and block-protect level into a protected
// row range and tells whether a given row address falls inside it.
// Assumes row addresses of 16 bits, 64 pages to a block.
`timescale 1ns/1ns
`default_nettype none

module nand_protect_range (
  input wire logic top_bottom_select,
  input wire logic [3:0] block_protect_level,
  input wire logic [15:0] row,
  output logic hit
);

  logic [4:0] shift_amt;
  logic [15:0] range_mask;
  logic level_none;
  logic level_all;
  logic upper_hit;
  logic lower_hit;

  assign shift_amt = {1'b0, block_protect_level} + 5'h06;
  assign range_mask = 16'hFFFF << shift_amt;
  assign upper_hit = (row & range_mask) == range_mask;
  assign lower_hit = (row & range_mask) == 16'h0000;
  assign level_none = block_protect_level == 4'h0;
  assign level_all = block_protect_level[3] & (block_protect_level[2] | block_protect_level[1]);
  assign hit = ~level_none & (level_all | (top_bottom_select ? lower_hit : upper_hit));

endmodule

`default_nettype wire

// ---- nand_busy_protect_ecc_ctrl.sv ----
// Busy flag, array write protection and ECC enable of a serial NAND device.
// Assumes an SPI mode 0 host whose clock is far slower than CLOCK, and a
// register port master that never issues read and write together.
// Operation
// - busy reads one during power-up and page read, program or erase.
// - while busy, only read status and read identification are honoured.
// - busy clears to zero when the internal operation completes.
// - reserved status bits read as zero; writing them changes nothing.
// - protect level n covers 2^n blocks at top or bottom; zero protects none.
// - levels 1x1x and 11xx protect the whole array.
// - program or erase touching the protected range is discarded.
// - array ECC corrects up to eight bits per sector.
// - ECC enable bit follows the configuration register write.
// - ECC enable comes up set after power-up.
// - device reset command keeps ECC enable and configuration.
// - refused program or erase sets its failure flag.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module nand_busy_protect_ecc_ctrl #(
  parameter int PWRUP_CYCLES = nand_bpe_pkg::PWRUP_CYC,
  parameter int READ_CYCLES = nand_bpe_pkg::READ_CYC,
  parameter int PROG_CYCLES = nand_bpe_pkg::PROG_CYC,
  parameter int ERASE_CYCLES = nand_bpe_pkg::ERASE_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ,
  output logic ECC_ENABLE,
  output logic OP_START,
  output logic [1:0] OP_KIND,
  output logic [15:0] OP_ROW,
  output logic OP_ECC
);

  // Synchronisers: stage 0 feeds stage 1 only; edges use stages 1 and 2.
  logic [2:0] sck_q;
  logic [2:0] cs_q;
  logic [1:0] mosi_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sck_q <= 3'h0;
      cs_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], SCK};
      cs_q <= {cs_q[1:0], CS_N};
      mosi_q <= {mosi_q[0], MOSI};
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_low;
  logic cs_start;
  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign cs_low = ~cs_q[1];
  assign cs_start = ~cs_q[1] & cs_q[2];

  // Frame and state registers.
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_idx_r;
  logic [6:0] rx_sh_r;
  logic [7:0] opcode_r;
  logic [7:0] feat_addr_r;
  logic [7:0] row_hi_r;
  logic ign_r;
  logic [7:0] tx_sh_r;
  logic tx_en_r;
  logic [nand_bpe_pkg::BUSY_W-1:0] busy_cnt_r;
  nand_bpe_pkg::op_kind_e op_kind_r;
  logic ecc_en_r;
  logic tb_r;
  logic [3:0] bp_r;
  logic pfail_r;
  logic efail_r;
  logic [nand_bpe_pkg::IRQ_W-1:0] irq_stat_r;
  logic [nand_bpe_pkg::IRQ_W-1:0] irq_mask_r;
  logic [31:0] rdata_r;
  logic op_start_r;
  logic [15:0] op_row_r;

  logic busy;
  assign busy = busy_cnt_r != '0;

  function automatic logic [7:0] feat_value(input logic [7:0] addr, input logic bsy,
                                            input logic pf, input logic ef, input logic ecc,
                                            input logic tb, input logic [3:0] bp);
    logic [7:0] v;
    v = 8'h00;
    if (addr == nand_bpe_pkg::FEAT_PROT) begin
      v[nand_bpe_pkg::PROT_TB_POS] = tb;
      v[nand_bpe_pkg::PROT_BP_LSB +: 4] = bp;
    end else if (addr == nand_bpe_pkg::FEAT_CFG) begin
      v[nand_bpe_pkg::CFG_ECC_POS] = ecc;
    end else if (addr == nand_bpe_pkg::FEAT_STAT) begin
      // reserved status bits read as zero.
      v[nand_bpe_pkg::STAT_BUSY_POS] = bsy;
      v[nand_bpe_pkg::STAT_EFAIL_POS] = ef;
      v[nand_bpe_pkg::STAT_PFAIL_POS] = pf;
    end
    return v;
  endfunction

  // Byte assembly and decode.
  logic byte_done;
  logic [7:0] rx_byte;
  logic op_byte;
  logic busy_allowed;
  logic cmd_ignored_ev;
  logic dev_reset;
  logic row_cmd;
  logic row_exec;
  logic [15:0] row_addr;
  logic prog_req;
  logic erase_req;
  logic read_req;
  logic prot_hit;
  logic reject;
  logic start;
  logic set_feat_wr;
  logic [7:0] tx_load;
  logic tx_load_en;

  assign byte_done = sck_rise & cs_low & (bit_cnt_r == 3'h7);
  assign rx_byte = {rx_sh_r, mosi_q[1]};
  assign op_byte = byte_done & (byte_idx_r == 3'h0);
  assign busy_allowed = (rx_byte == nand_bpe_pkg::OP_GET_FEAT) |
                        (rx_byte == nand_bpe_pkg::OP_READ_ID);
  // instructions other than status and ID are dropped while busy.
  assign cmd_ignored_ev = op_byte & busy & ~busy_allowed;
  // the reset command touches only the failure flags.
  assign dev_reset = op_byte & ~busy & (rx_byte == nand_bpe_pkg::OP_DEV_RESET);

  assign row_cmd = (opcode_r == nand_bpe_pkg::OP_PAGE_READ) |
                   (opcode_r == nand_bpe_pkg::OP_PROG_EXEC) |
                   (opcode_r == nand_bpe_pkg::OP_BLOCK_ERASE);
  assign row_exec = byte_done & (byte_idx_r == 3'h3) & ~ign_r & row_cmd;
  assign row_addr = {row_hi_r, rx_byte};
  assign prog_req = row_exec & (opcode_r == nand_bpe_pkg::OP_PROG_EXEC);
  assign erase_req = row_exec & (opcode_r == nand_bpe_pkg::OP_BLOCK_ERASE);
  assign read_req = row_exec & (opcode_r == nand_bpe_pkg::OP_PAGE_READ);

  // compared against the protection bits as they stand now.
  nand_protect_range u_range (
    .top_bottom_select(tb_r),
    .block_protect_level(bp_r),
    .row(row_addr),
    .hit(prot_hit)
  );

  // protected program or erase never starts.
  assign reject = (prog_req | erase_req) & prot_hit;
  assign start = row_exec & ~reject;

  assign set_feat_wr = byte_done & (byte_idx_r == 3'h2) & ~ign_r &
                       (opcode_r == nand_bpe_pkg::OP_SET_FEAT);

  // Reply byte loaded when a byte completes; status reads repeat live values.
  logic [7:0] reply_addr;
  assign reply_addr = (byte_idx_r == 3'h1) ? rx_byte : feat_addr_r;
  assign tx_load_en = byte_done & ~ign_r & (byte_idx_r != 3'h0) &
                      ((opcode_r == nand_bpe_pkg::OP_GET_FEAT) |
                       (opcode_r == nand_bpe_pkg::OP_READ_ID));
  assign tx_load = (opcode_r == nand_bpe_pkg::OP_GET_FEAT) ?
                   feat_value(reply_addr, busy, pfail_r, efail_r, ecc_en_r, tb_r, bp_r) :
                   (byte_idx_r == 3'h1) ? nand_bpe_pkg::ID_MAKER :
                   (byte_idx_r == 3'h2) ? nand_bpe_pkg::ID_DEVICE[15:8] :
                   (byte_idx_r == 3'h3) ? nand_bpe_pkg::ID_DEVICE[7:0] : 8'h00;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      bit_cnt_r <= 3'h0;
      byte_idx_r <= 3'h0;
      rx_sh_r <= 7'h00;
      opcode_r <= 8'h00;
      feat_addr_r <= 8'h00;
      row_hi_r <= 8'h00;
      ign_r <= 1'b0;
    end else if (cs_start) begin
      bit_cnt_r <= 3'h0;
      byte_idx_r <= 3'h0;
      ign_r <= 1'b0;
    end else if (sck_rise & cs_low) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= rx_byte[6:0];
      if (byte_done) begin
        if (byte_idx_r != 3'h7) begin
          byte_idx_r <= byte_idx_r + 3'h1;
        end
        if (byte_idx_r == 3'h0) begin
          opcode_r <= rx_byte;
          ign_r <= cmd_ignored_ev;
        end
        if (byte_idx_r == 3'h1) begin
          feat_addr_r <= rx_byte;
        end
        if (byte_idx_r == 3'h2) begin
          row_hi_r <= rx_byte;
        end
      end
    end
  end

  // Shift out on falling edges, except the one right after each byte completes, so the
  // first bit of each reply byte is held until the host samples it.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_sh_r <= 8'h00;
      tx_en_r <= 1'b0;
    end else if (cs_start) begin
      tx_sh_r <= 8'h00;
      tx_en_r <= 1'b0;
    end else if (tx_load_en) begin
      tx_sh_r <= tx_load;
      tx_en_r <= 1'b1;
    end else if (sck_fall & cs_low & (bit_cnt_r != 3'h0)) begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  assign MISO = tx_sh_r[7];
  assign MISO_OE = tx_en_r & cs_low;

  // Busy timer; reset stands for power-up.
  logic [nand_bpe_pkg::BUSY_W-1:0] busy_load;
  assign busy_load = prog_req ? nand_bpe_pkg::BUSY_W'(PROG_CYCLES) :
                     erase_req ? nand_bpe_pkg::BUSY_W'(ERASE_CYCLES) :
                     nand_bpe_pkg::BUSY_W'(READ_CYCLES);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      busy_cnt_r <= nand_bpe_pkg::BUSY_W'(PWRUP_CYCLES);
      op_kind_r <= nand_bpe_pkg::OPK_NONE;
    end else if (start) begin
      // busy while the array operation runs.
      busy_cnt_r <= busy_load;
      op_kind_r <= prog_req ? nand_bpe_pkg::OPK_PROG :
                   erase_req ? nand_bpe_pkg::OPK_ERASE : nand_bpe_pkg::OPK_READ;
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r - nand_bpe_pkg::BUSY_W'(1);
    end
  end

  logic done_ev;
  assign done_ev = busy_cnt_r == nand_bpe_pkg::BUSY_W'(1);

  // Feature registers. Writes to the status address are dropped whole.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ecc_en_r <= nand_bpe_pkg::ECC_EN_RST;
      tb_r <= nand_bpe_pkg::TB_RST;
      bp_r <= nand_bpe_pkg::BP_RST;
    end else if (set_feat_wr) begin
      // ECC enable follows bit 4 of the configuration byte.
      if (feat_addr_r == nand_bpe_pkg::FEAT_CFG) begin
        ecc_en_r <= rx_byte[nand_bpe_pkg::CFG_ECC_POS];
      end
      if (feat_addr_r == nand_bpe_pkg::FEAT_PROT) begin
        tb_r <= rx_byte[nand_bpe_pkg::PROT_TB_POS];
        bp_r <= rx_byte[nand_bpe_pkg::PROT_BP_LSB +: 4];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pfail_r <= 1'b0;
      efail_r <= 1'b0;
    end else begin
      // refused program or erase raises its failure flag.
      if (prog_req) begin
        pfail_r <= reject;
      end else if (dev_reset) begin
        pfail_r <= 1'b0;
      end
      if (erase_req) begin
        efail_r <= reject;
      end else if (dev_reset) begin
        efail_r <= 1'b0;
      end
    end
  end

  // Array operation request towards the array and its ECC engine.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      op_start_r <= 1'b0;
      op_row_r <= 16'h0000;
    end else begin
      op_start_r <= start;
      if (start) begin
        op_row_r <= row_addr;
      end
    end
  end

  assign OP_START = op_start_r;
  assign OP_ROW = op_row_r;
  assign OP_KIND = op_kind_r;
  // the array ECC engine corrects up to ECC_MAX_CORRECT bits when on.
  assign OP_ECC = ecc_en_r;
  assign ECC_ENABLE = ecc_en_r;

  // Register port. Interrupt status: set wins over write-one-to-clear.
  logic [nand_bpe_pkg::IRQ_W-1:0] irq_ev;
  logic [nand_bpe_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0] status_word;
  logic [31:0] rdata_nxt;

  assign irq_ev = {cmd_ignored_ev, reject, done_ev};
  assign irq_clr = (REG_WR & (REG_ADDR == nand_bpe_pkg::REG_IRQ_STAT)) ?
                   REG_WDATA[nand_bpe_pkg::IRQ_W-1:0] : '0;
  assign status_word = {6'h00, OP_KIND,
                        feat_value(nand_bpe_pkg::FEAT_CFG, busy, pfail_r, efail_r,
                                   ecc_en_r, tb_r, bp_r),
                        feat_value(nand_bpe_pkg::FEAT_PROT, busy, pfail_r, efail_r,
                                   ecc_en_r, tb_r, bp_r),
                        feat_value(nand_bpe_pkg::FEAT_STAT, busy, pfail_r, efail_r,
                                   ecc_en_r, tb_r, bp_r)};
  assign rdata_nxt = !REG_RD ? 32'h0000_0000 :
                     (REG_ADDR == nand_bpe_pkg::REG_STATUS) ? status_word :
                     (REG_ADDR == nand_bpe_pkg::REG_IRQ_STAT) ? {29'h0, irq_stat_r} :
                     (REG_ADDR == nand_bpe_pkg::REG_IRQ_MASK) ? {29'h0, irq_mask_r} :
                     32'h0000_0000;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      if (REG_WR & (REG_ADDR == nand_bpe_pkg::REG_IRQ_MASK)) begin
        irq_mask_r <= REG_WDATA[nand_bpe_pkg::IRQ_W-1:0];
      end
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign IRQ = |(irq_stat_r & irq_mask_r);

endmodule

`default_nettype wire

// ---- nand_bpe_monitor.sv ----
// Port checker for the busy, protection and ECC-enable block.
// Assumes it sees only the top module's ports, bound to every instance.
`timescale 1ns/1ns
`default_nettype none
module nand_bpe_monitor (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic MISO_OE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic IRQ,
  input wire logic ECC_ENABLE,
  input wire logic OP_START,
  input wire logic [1:0] OP_KIND,
  input wire logic [15:0] OP_ROW,
  input wire logic OP_ECC
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside a read reply");
  chk_start_pulse: assert property (OP_START |=> !OP_START)
    else $error("op start longer than one cycle");
  chk_start_kind: assert property (OP_START |-> OP_KIND != 2'h0)
    else $error("op started without a kind");
  chk_ecc_follow: assert property (OP_ECC == ECC_ENABLE)
    else $error("array ECC request differs from enable");
  chk_ecc_on_link: assert property ($changed(ECC_ENABLE) |-> !$past(CS_N, 4))
    else $error("ECC enable changed outside a frame");
  chk_op_hold: assert property (!OP_START |-> $stable(OP_ROW) && $stable(OP_KIND))
    else $error("op row or kind changed without a start");
  chk_start_in_frame: assert property (OP_START |-> !$past(CS_N, 2))
    else $error("op started outside a frame");
  chk_irq_masked: assert property (REG_WR && REG_ADDR == nand_bpe_pkg::REG_IRQ_MASK &&
      REG_WDATA[2:0] == 3'h0 |-> ##2 !IRQ)
    else $error("interrupt high with mask cleared");
  chk_oe_idle: assert property (CS_N [*4] |-> !MISO_OE)
    else $error("data out driven while deselected");
  chk_status_ecc: assert property (REG_RD && REG_ADDR == nand_bpe_pkg::REG_STATUS |=>
      REG_RDATA[20] == $past(ECC_ENABLE))
    else $error("status read shows wrong ECC enable");
  cover property (OP_START && OP_KIND == 2'h3);
  cover property ($rose(IRQ));
  cover property ($fell(ECC_ENABLE));
  cover property (OP_START && OP_KIND == 2'h1);
endmodule

bind nand_busy_protect_ecc_ctrl nand_bpe_monitor u_mon (.CLOCK(CLOCK), .RST_N(RST_N),
  .CS_N(CS_N), .MISO_OE(MISO_OE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
  .ECC_ENABLE(ECC_ENABLE), .OP_START(OP_START), .OP_KIND(OP_KIND), .OP_ROW(OP_ROW),
  .OP_ECC(OP_ECC));
`default_nettype wire

// ---- nand_spi_host.sv ----
// Host serial link model: mode 0, MSB first, 320 ns bit period.
// Assumes the device samples on SCK rise and shifts its reply on SCK fall.
`timescale 1ns/1ns
`default_nettype none
module nand_spi_host (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // The clock stands low between frames and released MOSI shows the inverse level.
  // Link edges may fall on a core clock edge, so they are scheduled non-blocking.
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = 40'h0;
    cs_n <= 1'b0;
    #160;
    for (int i = 0; i < n * 8; i++) begin
      mosi <= tx[39 - i];
      #160;
      sck <= 1'b1;
      rx[39 - i] = miso;
      #160;
      sck <= 1'b0;
    end
    #160;
    cs_n <= 1'b1;
    mosi <= ~mosi;
    #640;
  endtask
  task automatic set_feature(input logic [7:0] addr, input logic [7:0] data);
    logic [39:0] rx;
    xfer({nand_bpe_pkg::OP_SET_FEAT, addr, data, 16'h0}, 3, rx);
  endtask
endmodule
`default_nettype wire

// ---- nand_bpe_tb.sv ----
// Self-checking bench: register port, host link model and array-op outputs.
// Assumes short internal op counts so that the run stays brief.
`timescale 1ns/1ns
`default_nettype none
module nand_busy_protect_ecc_ctrl_tb_top;
  logic clock, rst_n, sck, cs_n, mosi, miso, miso_oe, miso_line;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic reg_wr, reg_rd, irq, ecc_enable, op_start, op_ecc;
  logic [1:0] op_kind;
  logic [15:0] op_row;
  logic [39:0] rx;
  int err_total, checked, starts;
  // A released data line shows a changing pattern, never the last bit.
  assign miso_line = miso_oe ? miso : ~sck;
  nand_spi_host u_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_line));
  nand_busy_protect_ecc_ctrl #(.PWRUP_CYCLES(20), .READ_CYCLES(30), .PROG_CYCLES(40),
    .ERASE_CYCLES(2000)) u_dut (.CLOCK(clock), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n),
    .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .IRQ(irq), .ECC_ENABLE(ecc_enable), .OP_START(op_start), .OP_KIND(op_kind),
    .OP_ROW(op_row), .OP_ECC(op_ecc));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (op_start === 1'b1) starts++;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    reg_read(nand_bpe_pkg::REG_STATUS, rd);
    while (rd[0] !== 1'b0 && k < 1000) begin
      reg_read(nand_bpe_pkg::REG_STATUS, rd);
      k++;
    end
    check("busy cleared", 32'h0, 32'(rd[0]));
  endtask
  function automatic logic exp_hit(logic t, logic [3:0] b, logic [15:0] r);
    int sz;
    if (b[3] && (b[2] || b[1])) return 1'b1;
    if (b == 4'h0) return 1'b0;
    sz = 64 << b;
    return t ? (r < sz) : (r >= 65536 - sz);
  endfunction
  task automatic t_reset;
    reg_read(nand_bpe_pkg::REG_STATUS, rd);
    check("busy at power-up", 32'h1, 32'(rd[0]));
    check("ECC enable at power-up", 32'h1, 32'(rd[20]));
    wait_ready;
    reg_read(nand_bpe_pkg::REG_IRQ_STAT, rd);
    check("done event", 32'h1, 32'(rd[0]));
  endtask
  task automatic t_ecc;
    u_host.set_feature(nand_bpe_pkg::FEAT_CFG, 8'h00);
    check("ECC off", 32'h0, 32'(ecc_enable));
    check("array ECC off", 32'h0, 32'(op_ecc));
    u_host.xfer({nand_bpe_pkg::OP_DEV_RESET, 32'h0}, 1, rx);
    check("ECC kept by reset", 32'h0, 32'(ecc_enable));
    u_host.set_feature(nand_bpe_pkg::FEAT_STAT, 8'hFF);
    reg_read(nand_bpe_pkg::REG_STATUS, rd);
    // Only busy and the two fail flags are judged; the rest may read either way.
    check("status write ignored", 32'h0, 32'(rd[7:0] & 8'h0D));
    u_host.set_feature(nand_bpe_pkg::FEAT_CFG, 8'h10);
    check("ECC on", 32'h1, 32'(ecc_enable));
  endtask
  task automatic t_protect;
    int sz, n0;
    logic [15:0] row;
    logic hit;
    logic [7:0] cmd;
    for (int t = 0; t < 2; t++) begin
      for (int b = 0; b < 16; b++) begin
        for (int j = 0; j < 2; j++) begin
          sz = 64 << ((b > 9) ? 0 : b);
          row = 16'(t ? (sz - 64 + 64 * j) : (65536 - sz - 64 * j));
          hit = exp_hit(t[0], b[3:0], row);
          cmd = j ? nand_bpe_pkg::OP_PROG_EXEC : nand_bpe_pkg::OP_BLOCK_ERASE;
          n0 = starts;
          u_host.set_feature(nand_bpe_pkg::FEAT_PROT, {1'b0, b[3:0], t[0], 2'b00});
          u_host.xfer({cmd, 8'h00, row, 8'h00}, 4, rx);
          check("op started", 32'(!hit), starts - n0);
          if (!hit) check("op row", 32'(row), 32'(op_row));
          if (!hit) check("op kind", j ? 32'h2 : 32'h3, 32'(op_kind));
          wait_ready;
          check("fail flag", 32'(hit), 32'(j ? rd[3] : rd[2]));
        end
      end
    end
  endtask
  task automatic t_irq;
    reg_write(nand_bpe_pkg::REG_IRQ_STAT, 32'h7);
    reg_read(nand_bpe_pkg::REG_IRQ_STAT, rd);
    check("irq status cleared", 32'h0, rd);
    reg_write(nand_bpe_pkg::REG_IRQ_MASK, 32'h2);
    u_host.set_feature(nand_bpe_pkg::FEAT_PROT, 8'h60);
    u_host.xfer({nand_bpe_pkg::OP_PROG_EXEC, 32'h00123400}, 4, rx);
    check("reject interrupt", 32'h1, 32'(irq));
    // A page read is never refused, even inside the protected range.
    u_host.xfer({nand_bpe_pkg::OP_PAGE_READ, 32'h00123400}, 4, rx);
    check("read kind", 32'h1, 32'(op_kind));
    check("read row", 32'h1234, 32'(op_row));
    wait_ready;
    reg_write(nand_bpe_pkg::REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clock);
    check("masked interrupt", 32'h0, 32'(irq));
    reg_write(nand_bpe_pkg::REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clock);
    check("unmasked interrupt", 32'h1, 32'(irq));
    reg_write(nand_bpe_pkg::REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clock);
    check("cleared interrupt", 32'h0, 32'(irq));
    reg_read(8'hFC, rd);
    check("unmapped read", 32'h0, rd);
  endtask
  task automatic t_busy;
    reg_write(nand_bpe_pkg::REG_IRQ_STAT, 32'h7);
    u_host.set_feature(nand_bpe_pkg::FEAT_PROT, 8'h00);
    u_host.xfer({nand_bpe_pkg::OP_BLOCK_ERASE, 32'h00004000}, 4, rx);
    check("erase kind", 32'h3, 32'(op_kind));
    u_host.xfer({nand_bpe_pkg::OP_GET_FEAT, nand_bpe_pkg::FEAT_STAT, 24'h0}, 3, rx);
    check("busy on link", 32'h1, 32'(rx[16]));
    u_host.xfer({nand_bpe_pkg::OP_READ_ID, 32'h0}, 5, rx);
    check("id while busy", 32'(nand_bpe_pkg::ID_MAKER), 32'(rx[23:16]));
    u_host.set_feature(nand_bpe_pkg::FEAT_CFG, 8'h00);
    check("ECC kept while busy", 32'h1, 32'(ecc_enable));
    wait_ready;
    reg_read(nand_bpe_pkg::REG_IRQ_STAT, rd);
    check("ignored and done events", 32'h5, 32'(rd[2:0] & 3'h5));
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_ecc;
    t_protect;
    t_irq;
    t_busy;
    end_of_test;
  end
  initial begin
    #3000000;
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
